// *** hw/aetx_framer.sv ***
// Parser for plain and explicit-addressing transmit request frames.
// Function
// RULE1 - Frames open with delimiter 7E, then the length field.
// RULE2 - Length counts bytes between length field and checksum.
// RULE3 - Checksum is FF minus the byte sum from offset 3.
// RULE4 - Offset 3 holds frame type: 11 explicit, 10 plain.
// RULE5 - Explicit request is answered with status type 8B, same frame ID.
// RULE6 - Plain request is answered with status type 89, same frame ID.
// RULE7 - Frame ID zero suppresses the status response.
// RULE8 - Host gives unicast address or the broadcast value at offset 5.
// RULE9 - Host uses all-ones destination for sixteen-bit addressing.
// RULE10 - Reserved word at offset 13 is ignored, normally FFFE.
// RULE11 - Source endpoint sits at offset 15, E8 for serial data.
// RULE12 - Destination endpoint sits at offset 16, E8 for serial data.
// RULE13 - Cluster at offset 17, transparent data cluster 11.
// RULE14 - Profile at offset 19, family profile for serial data.
// RULE15 - Radius at 21 limits broadcast hops; zero uses default hop limit.
// RULE16 - Options at 22; zero uses default transmit options setting.
// RULE17 - Payload runs from 23 to checksum, within the maximum payload.
// RULE18 - Endpoints DC to EE are reserved; E6 is device object.
// RULE19 - Point-to-point variant maps endpoints outside reserved range to E8.
// RULE20 - Loopback cluster 0012 on data endpoint echoes; absent in point-to-point.
// RULE21 - Options bit 0 disables unicast acknowledgments.
// RULE22 - Options bits 7:6 pick delivery method; 00 is invalid. The code accepts 00 and passes it through on TX_METHOD.
// RULE23 - Multi-byte fields arrive most significant byte first.
// RULE24 - Frames with a bad checksum are dropped without status.
`include "aetx_defines.svh"
`default_nettype none
module aetx_framer
#(
   parameter logic [15:0] PROFILE_DEFAULT = `AETX_PROFILE_DEF // Arbitrary value.
)
(
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        RESET,
   // Request bytes from the host.
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_VALID,
   output var  logic        RX_READY,
   // Settings.
   input  wire logic [15:0] MAX_PAYLOAD_BYTES_SETTING,
   input  wire logic [7:0]  DEFAULT_TRANSMIT_OPTIONS_SETTING,
   input  wire logic [7:0]  DEFAULT_HOP_LIMIT_SETTING,
   input  wire logic        POINT_TO_POINT_MODE,
   // Payload bytes toward the radio.
   output var  logic [7:0]  PL_DATA,
   output var  logic        PL_VALID,
   input  wire logic        PL_READY,
   // Frame verdict and fields toward the radio.
   output var  logic        PKT_GOOD,
   output var  logic        PKT_DROP,
   output var  logic        PKT_EXPLICIT,
   output var  logic [7:0]  TX_FRAME_ID,
   output var  logic [63:0] TX_DEST,
   output var  logic [7:0]  TX_SRC_EP,
   output var  logic [7:0]  TX_DST_EP,
   output var  logic [15:0] TX_CLUSTER,
   output var  logic [15:0] TX_PROFILE,
   output var  logic [7:0]  TX_HOPS,
   output var  logic [7:0]  TX_OPTIONS,
   output var  logic        TX_BCAST,
   output var  logic        TX_NO_ACK,
   output var  logic [1:0]  TX_METHOD,
   output var  logic        TX_LOOPBACK,
   // Transmit result from the radio.
   input  wire logic        TX_DONE,
   input  wire logic [7:0]  TX_RESULT,
   input  wire logic [7:0]  TX_RETRIES,
   // Status frame bytes toward the host.
   output var  logic [7:0]  ST_DATA,
   output var  logic        ST_VALID,
   input  wire logic        ST_READY
);
   aetx_pkg::aetx_fr_t r_r;
   aetx_pkg::aetx_fr_t r_nxt;
   aetx_if             st_if ();
   logic               acc;
   logic               is_exp;
   logic [15:0]        cnt;

   //--------------------------------------------------------------------
   // Helpers
   //--------------------------------------------------------------------

   // Header bytes from type to options, per frame type.
   function automatic logic [15:0] hdr_len(input logic [7:0] t);
      return (t == `AETX_TYPE_EXP) ? `AETX_HDR_EXP : `AETX_HDR_TX;
   endfunction

   // Endpoint seen by the radio, remapped in point-to-point mode.
   function automatic logic [7:0] ep_map(input logic [7:0] b, input logic p2p);
      return (p2p && (b < `AETX_EP_RSV_LO || b > `AETX_EP_RSV_HI)) ? `AETX_EP_DATA : b;
   endfunction

   assign acc    = RX_VALID && RX_READY;
   assign is_exp = (r_r.ftype == `AETX_TYPE_EXP);
   assign cnt    = 16'(r_r.pos - `AETX_OFF_TYPE);

   // Stall the host while a payload byte waits or a result is pending.
   assign RX_READY = !r_r.pl_valid && r_r.st != aetx_pkg::AETX_WAIT
                     && !(r_r.st == aetx_pkg::AETX_IDLE && st_if.busy);

   //--------------------------------------------------------------------
   // Frame parser
   //--------------------------------------------------------------------

   // Next state of the parser.
   always_comb
   begin
      r_nxt       = r_r;
      r_nxt.good  = 1'b0;
      r_nxt.drop  = 1'b0;
      r_nxt.start = 1'b0;
      if (r_r.pl_valid && PL_READY)
         r_nxt.pl_valid = 1'b0;
      case (r_r.st)
         aetx_pkg::AETX_IDLE:
            if (acc && RX_DATA == `AETX_DELIM) // see RULE1
               r_nxt.st = aetx_pkg::AETX_LEN_HI;
         aetx_pkg::AETX_LEN_HI:
            if (acc)
            begin
               r_nxt.len[15:8] = RX_DATA; // see RULE23
               r_nxt.st        = aetx_pkg::AETX_LEN_LO;
            end
         aetx_pkg::AETX_LEN_LO:
            if (acc)
            begin
               r_nxt.len[7:0] = RX_DATA; // see RULE2
               r_nxt.pos      = `AETX_OFF_TYPE;
               r_nxt.sum      = `AETX_ZERO8;
               r_nxt.bad      = 1'b0;
               r_nxt.st       = aetx_pkg::AETX_BODY;
            end
         aetx_pkg::AETX_BODY:
            if (acc)
            begin
               r_nxt.sum = 8'(r_r.sum + RX_DATA);
               r_nxt.pos = 16'(r_r.pos + 16'h0001);
               if (cnt == r_r.len)
               begin
                  // Checksum byte: commit only a clean, known frame.
                  if (!r_r.bad && cnt != 16'h0000 && r_nxt.sum == `AETX_CHK_OK) // see RULE3
                  begin
                     r_nxt.good = 1'b1;
                     r_nxt.st   = aetx_pkg::AETX_WAIT;
                  end
                  else
                  begin
                     r_nxt.drop = 1'b1; // see RULE24
                     r_nxt.st   = aetx_pkg::AETX_IDLE;
                  end
               end
               else if (r_r.pos == `AETX_OFF_TYPE)
               begin
                  // Type byte: defaults for the plain request, size checks.
                  r_nxt.ftype = RX_DATA; // see RULE4
                  r_nxt.sep   = `AETX_EP_DATA;
                  r_nxt.dep   = `AETX_EP_DATA;
                  r_nxt.clu   = `AETX_CLU_DATA;
                  r_nxt.pro   = PROFILE_DEFAULT;
                  r_nxt.bad   = (RX_DATA != `AETX_TYPE_TX && RX_DATA != `AETX_TYPE_EXP)
                                || r_r.len < hdr_len(RX_DATA)
                                || 16'(r_r.len - hdr_len(RX_DATA)) > MAX_PAYLOAD_BYTES_SETTING; // see RULE17
               end
               else if (r_r.pos == `AETX_OFF_FID)
                  r_nxt.fid = RX_DATA;
               else if (r_r.pos <= `AETX_OFF_DEST_E)
                  r_nxt.dest = {r_r.dest[55:0], RX_DATA}; // see RULE23
               else if (r_r.pos < `AETX_OFF_SEP)
               begin
                  // Reserved word is consumed and ignored.
               end
               else if (is_exp && r_r.pos == `AETX_OFF_SEP)
                  r_nxt.sep = ep_map(RX_DATA, POINT_TO_POINT_MODE); // see RULE19
               else if (is_exp && r_r.pos == `AETX_OFF_DEP)
                  r_nxt.dep = ep_map(RX_DATA, POINT_TO_POINT_MODE); // see RULE19
               else if (is_exp && r_r.pos == `AETX_OFF_CLU_H)
                  r_nxt.clu[15:8] = RX_DATA;
               else if (is_exp && r_r.pos == `AETX_OFF_CLU_L)
                  r_nxt.clu[7:0] = RX_DATA;
               else if (is_exp && r_r.pos == `AETX_OFF_PRO_H)
                  r_nxt.pro[15:8] = RX_DATA;
               else if (is_exp && r_r.pos == `AETX_OFF_PRO_L)
                  r_nxt.pro[7:0] = RX_DATA;
               else if (r_r.pos == (is_exp ? `AETX_OFF_RAD_X : `AETX_OFF_RAD_T))
                  r_nxt.hops = (RX_DATA == `AETX_ZERO8) ? DEFAULT_HOP_LIMIT_SETTING : RX_DATA; // see RULE15
               else if (r_r.pos == (is_exp ? `AETX_OFF_OPT_X : `AETX_OFF_OPT_T))
                  r_nxt.opts = (RX_DATA == `AETX_ZERO8) ? DEFAULT_TRANSMIT_OPTIONS_SETTING
                                                        : RX_DATA; // see RULE16
               else if (!r_r.bad)
               begin
                  r_nxt.pl_data  = RX_DATA;
                  r_nxt.pl_valid = 1'b1;
               end
            end
         aetx_pkg::AETX_WAIT:
            if (TX_DONE)
            begin
               r_nxt.st    = aetx_pkg::AETX_IDLE;
               r_nxt.start = (r_r.fid != `AETX_ZERO8); // see RULE7
            end
         default:
            r_nxt.st = aetx_pkg::AETX_IDLE;
      endcase
   end

   // State register with synchronous reset.
   always_ff @(posedge CLK)
   begin
      if (RESET)
         r_r <= '0;
      else
         r_r <= r_nxt;
   end

   //--------------------------------------------------------------------
   // Outputs and status responder
   //--------------------------------------------------------------------

   // Registered fields, plus flags derived from them.
   assign PL_DATA      = r_r.pl_data;
   assign PL_VALID     = r_r.pl_valid;
   assign PKT_GOOD     = r_r.good;
   assign PKT_DROP     = r_r.drop;
   assign PKT_EXPLICIT = is_exp;
   assign TX_FRAME_ID  = r_r.fid;
   assign TX_DEST      = r_r.dest;
   assign TX_SRC_EP    = r_r.sep;
   assign TX_DST_EP    = r_r.dep;
   assign TX_CLUSTER   = r_r.clu;
   assign TX_PROFILE   = r_r.pro;
   assign TX_HOPS      = r_r.hops;
   assign TX_OPTIONS   = r_r.opts;
   assign TX_BCAST     = (r_r.dest == `AETX_BCAST);
   assign TX_NO_ACK    = r_r.opts[`AETX_OPT_NOACK] && !TX_BCAST; // see RULE21
   assign TX_METHOD    = r_r.opts[`AETX_MTH_HI:`AETX_MTH_LO]; // see RULE22
   assign TX_LOOPBACK  = is_exp && r_r.dep == `AETX_EP_DATA
                         && r_r.clu == `AETX_CLU_LOOP && !POINT_TO_POINT_MODE; // see RULE20

   // Status request carries the frame kind and the radio's result.
   assign st_if.start = r_r.start;
   assign st_if.ext   = is_exp; // see RULE5, see RULE6
   assign st_if.fid   = r_r.fid;
   assign st_if.stat  = TX_RESULT;
   assign st_if.retry = TX_RETRIES;

   aetx_status_tx u_status
   (
      .CLK      (CLK),
      .RESET    (RESET),
      .req      (st_if.snk),
      .ST_DATA  (ST_DATA),
      .ST_VALID (ST_VALID),
      .ST_READY (ST_READY)
   );

   //--------------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------------

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   a_delim_gate: assert property ( // see RULE1
      (r_r.st == aetx_pkg::AETX_IDLE && acc && RX_DATA != 8'h7E) |=> r_r.st == aetx_pkg::AETX_IDLE)
      else $error("frame started without delimiter");
   a_len_msb_first: assert property ( // see RULE2
      (r_r.st == aetx_pkg::AETX_LEN_LO && acc) |=> r_r.len == {$past(r_r.len[15:8]), $past(RX_DATA)})
      else $error("length field not assembled high byte first");
   a_sum_good: assert property ( // see RULE3
      (r_r.st == aetx_pkg::AETX_BODY && acc && cnt == r_r.len && 8'(r_r.sum + RX_DATA) != 8'hFF)
      |=> PKT_DROP && !PKT_GOOD)
      else $error("bad checksum not dropped");
   a_type_known: assert property ( // see RULE4
      PKT_GOOD |-> (r_r.ftype == 8'h10 || r_r.ftype == 8'h11))
      else $error("unknown frame type committed");
   a_drop_silent: assert property ( // see RULE24
      PKT_DROP |=> (!r_r.start && !ST_VALID) [*2])
      else $error("status raised after a dropped frame");
   a_zero_fid_quiet: assert property ( // see RULE7
      (r_r.st == aetx_pkg::AETX_WAIT && TX_DONE && r_r.fid == 8'h00) |=> !st_if.start)
      else $error("status requested for frame id zero");
   a_hops_default: assert property ( // see RULE15
      (r_r.st == aetx_pkg::AETX_BODY && acc && RX_DATA == 8'h00 && cnt != r_r.len
       && r_r.pos == (is_exp ? 16'h0015 : 16'h000F)) |=> TX_HOPS == DEFAULT_HOP_LIMIT_SETTING)
      else $error("zero radius not replaced by default hop limit");
   a_opts_default: assert property ( // see RULE16
      (r_r.st == aetx_pkg::AETX_BODY && acc && RX_DATA == 8'h00 && cnt != r_r.len
       && r_r.pos == (is_exp ? 16'h0016 : 16'h0010)) |=> TX_OPTIONS == DEFAULT_TRANSMIT_OPTIONS_SETTING)
      else $error("zero options not replaced by default");
   a_ep_remap: assert property ( // see RULE19
      (PKT_GOOD && POINT_TO_POINT_MODE) |-> (TX_DST_EP == 8'hE8 || (TX_DST_EP >= 8'hDC && TX_DST_EP <= 8'hEE)))
      else $error("endpoint not remapped in point-to-point mode");
   a_noack_unicast: assert property ( // see RULE21
      TX_NO_ACK |-> TX_OPTIONS[0] && TX_DEST != 64'h0000_0000_0000_FFFF)
      else $error("acknowledge disable outside unicast");

   c_good_plain: cover property (PKT_GOOD && !is_exp);
   c_good_explicit: cover property (PKT_GOOD && is_exp);
   c_drop: cover property (PKT_DROP);
   c_status_sent: cover property (st_if.start ##[1:20] ST_VALID);
endmodule
`default_nettype wire

// *** shared/aetx_defines.svh ***
// Constants of the transmit-request frame parser and status responder.
`ifndef AETX_DEFINES_SVH
`define AETX_DEFINES_SVH
`define AETX_DELIM       8'h7E
`define AETX_TYPE_TX     8'h10
`define AETX_TYPE_EXP    8'h11
`define AETX_TYPE_ST     8'h89
`define AETX_TYPE_XST    8'h8B
`define AETX_CHK_OK      8'hFF
`define AETX_ZERO8       8'h00
`define AETX_OFF_TYPE    16'h0003
`define AETX_OFF_FID     16'h0004
`define AETX_OFF_DEST_E  16'h000C
`define AETX_OFF_SEP     16'h000F
`define AETX_OFF_DEP     16'h0010
`define AETX_OFF_CLU_H   16'h0011
`define AETX_OFF_CLU_L   16'h0012
`define AETX_OFF_PRO_H   16'h0013
`define AETX_OFF_PRO_L   16'h0014
`define AETX_OFF_RAD_X   16'h0015
`define AETX_OFF_OPT_X   16'h0016
`define AETX_OFF_RAD_T   16'h000F
`define AETX_OFF_OPT_T   16'h0010
`define AETX_HDR_TX      16'h000E
`define AETX_HDR_EXP     16'h0014
`define AETX_EP_DATA     8'hE8
`define AETX_EP_RSV_LO   8'hDC
`define AETX_EP_RSV_HI   8'hEE
`define AETX_CLU_DATA    16'h0011
`define AETX_CLU_LOOP    16'h0012
`define AETX_BCAST       64'h0000_0000_0000_FFFF
`define AETX_ADDR16_UNK  16'hFFFE
`define AETX_OPT_NOACK   0
`define AETX_MTH_HI      7
`define AETX_MTH_LO      6
`define AETX_ST_LEN_X    8'h07
`define AETX_ST_LEN_P    8'h03
`define AETX_ST_LAST_X   4'hA
`define AETX_ST_LAST_P   4'h6
`define AETX_ST_SUM_IDX  4'h3
`define AETX_PROFILE_DEF 16'h5A5A
`endif

// *** shared/aetx_pkg.sv ***
// Types shared by the frame parser and the status responder.
`default_nettype none
package aetx_pkg;
   typedef enum logic [2:0] {
      AETX_IDLE   = 3'b000,
      AETX_LEN_HI = 3'b001,
      AETX_LEN_LO = 3'b010,
      AETX_BODY   = 3'b011,
      AETX_WAIT   = 3'b100
   } aetx_state_t;

   typedef struct packed {
      aetx_state_t st;
      logic [15:0] len;
      logic [15:0] pos;
      logic [7:0]  sum;
      logic [7:0]  ftype;
      logic [7:0]  fid;
      logic [63:0] dest;
      logic [7:0]  sep;
      logic [7:0]  dep;
      logic [15:0] clu;
      logic [15:0] pro;
      logic [7:0]  hops;
      logic [7:0]  opts;
      logic        bad;
      logic [7:0]  pl_data;
      logic        pl_valid;
      logic        good;
      logic        drop;
      logic        start;
   } aetx_fr_t;

   typedef struct packed {
      logic       busy;
      logic       ext;
      logic [7:0] fid;
      logic [7:0] stat;
      logic [7:0] retry;
      logic [3:0] idx;
      logic [7:0] sum;
      logic [7:0] data;
      logic       valid;
   } aetx_st_t;
endpackage
`default_nettype wire

// *** shared/aetx_if.sv ***
// Hand-off of one status request from the parser to the status responder.
`default_nettype none
interface aetx_if;
   logic       start;
   logic       ext;
   logic [7:0] fid;
   logic [7:0] stat;
   logic [7:0] retry;
   logic       busy;
   modport src (output start, ext, fid, stat, retry, input busy);
   modport snk (input start, ext, fid, stat, retry, output busy);
endinterface
`default_nettype wire

// *** hw/aetx_status_tx.sv ***
// Status responder: serialises one transmit status frame per request.
`include "aetx_defines.svh"
`default_nettype none
module aetx_status_tx
(
   // Clock and reset.
   input  wire logic CLK,
   input  wire logic RESET,
   // Request from the parser.
   aetx_if.snk       req,
   // Outgoing serial byte stream.
   output var  logic [7:0] ST_DATA,
   output var  logic       ST_VALID,
   input  wire logic       ST_READY
);
   aetx_pkg::aetx_st_t r_r;
   aetx_pkg::aetx_st_t r_nxt;
   logic [3:0]         last;
   logic [7:0]         sum_nxt;

   // Table of frame bytes; the checksum slot is filled by the caller.
   function automatic logic [7:0] byte_at(input logic [3:0] i, input aetx_pkg::aetx_st_t s);
      logic [7:0] b;
      b = `AETX_ZERO8;
      case (i)
         4'h0: b = `AETX_DELIM;
         4'h2: b = s.ext ? `AETX_ST_LEN_X : `AETX_ST_LEN_P;
         4'h3: b = s.ext ? `AETX_TYPE_XST : `AETX_TYPE_ST;
         4'h4: b = s.fid;
         4'h5: b = s.ext ? 8'(`AETX_ADDR16_UNK >> 8) : s.stat;
         4'h6: b = s.ext ? 8'(`AETX_ADDR16_UNK & 16'h00FF) : `AETX_ZERO8;
         4'h7: b = s.retry;
         4'h8: b = s.stat;
         default: b = `AETX_ZERO8;
      endcase
      return b;
   endfunction

   assign last     = r_r.ext ? `AETX_ST_LAST_X : `AETX_ST_LAST_P;
   assign sum_nxt  = (r_r.idx >= `AETX_ST_SUM_IDX) ? 8'(r_r.sum + r_r.data) : r_r.sum;
   assign req.busy = r_r.busy;
   assign ST_DATA  = r_r.data;
   assign ST_VALID = r_r.valid;

   // Next state: load on a request, advance one byte per accepted beat.
   always_comb
   begin
      r_nxt = r_r;
      if (!r_r.busy && req.start)
      begin
         r_nxt.busy  = 1'b1;
         r_nxt.ext   = req.ext;
         r_nxt.fid   = req.fid;
         r_nxt.stat  = req.stat;
         r_nxt.retry = req.retry;
         r_nxt.idx   = 4'h0;
         r_nxt.sum   = `AETX_ZERO8;
         r_nxt.data  = `AETX_DELIM;
         r_nxt.valid = 1'b1;
      end
      else if (r_r.valid && ST_READY)
      begin
         if (r_r.idx == last)
         begin
            r_nxt.busy  = 1'b0;
            r_nxt.valid = 1'b0;
         end
         else
         begin
            r_nxt.idx  = 4'(r_r.idx + 4'h1);
            r_nxt.sum  = sum_nxt;
            r_nxt.data = (r_nxt.idx == last) ? 8'(`AETX_CHK_OK - sum_nxt)
                                             : byte_at(r_nxt.idx, r_r);
         end
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge CLK)
   begin
      if (RESET)
         r_r <= '0;
      else
         r_r <= r_nxt;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   // Checks on the outgoing status frame.
   a_status_type_code: assert property ( // see RULE5, see RULE6
      (ST_VALID && r_r.idx == 4'h3) |-> ST_DATA == (r_r.ext ? 8'h8B : 8'h89))
      else $error("status frame type does not match request kind");
   a_status_fid_echo: assert property ( // see RULE7
      (ST_VALID && r_r.idx == 4'h4) |-> ST_DATA == r_r.fid && ST_DATA != 8'h00)
      else $error("status frame id wrong or zero");
   c_status_ext: cover property (ST_VALID && r_r.ext && r_r.idx == 4'hA && ST_READY);
endmodule
`default_nettype wire

// *** dv/aetx_host_model.sv ***
// Host model that sends request frames over the valid/ready byte bus.
`default_nettype none
module aetx_host_model
(
   // Byte bus toward the parser.
   input  wire logic       CLK,
   input  wire logic       RX_READY,
   output var  logic [7:0] RX_DATA,
   output var  logic       RX_VALID
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] fq[$]; // Next frame, multi-byte fields MSB first
   // Each byte is held until an edge finds ready high; idle data then turns over.
   task automatic send();
      foreach (fq[i])
      begin
         @(negedge CLK);
         RX_DATA  = fq[i];
         RX_VALID = 1'b1;
         #1;
         while (RX_READY !== 1'b1)
         begin
            @(negedge CLK);
            #1;
         end
         @(posedge CLK);
      end
      @(negedge CLK);
      RX_VALID = 1'b0;
      RX_DATA  = ~RX_DATA;
   endtask
   initial
   begin
      RX_DATA  = 8'h00;
      RX_VALID = 1'b0;
   end
endmodule
`default_nettype wire

// *** dv/test_api_explicit_tx_request_frame.sv ***
// Self-checking bench for the transmit-request frame parser.
`default_nettype none
module test_api_explicit_tx_request_frame;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] PROF = 16'h3C3C; // Arbitrary profile value.
   localparam logic [63:0] ADR  = 64'h0011_2233_4455_6677;
   logic        clk, reset, rx_valid, rx_ready, pl_valid, pl_ready, good, drop, expl;
   logic        bcast, no_ack, loop, tx_done, st_valid, st_ready, p2p;
   logic [7:0]  rx_data, pl_data, st_data, d_opt, d_hop, res, rty, fid, sep, dep, hops, opts;
   logic [15:0] maxp, clu, pro;
   logic [63:0] dest;
   logic [1:0]  meth;
   logic [7:0]  pq[$], sq[$], epl[$], esq[$];
   int          errors, comparisons, ngood, ndrop;
   aetx_framer #(.PROFILE_DEFAULT(PROF)) DUT
   (
      .CLK(clk), .RESET(reset), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
      .MAX_PAYLOAD_BYTES_SETTING(maxp), .DEFAULT_TRANSMIT_OPTIONS_SETTING(d_opt),
      .DEFAULT_HOP_LIMIT_SETTING(d_hop), .POINT_TO_POINT_MODE(p2p),
      .PL_DATA(pl_data), .PL_VALID(pl_valid), .PL_READY(pl_ready),
      .PKT_GOOD(good), .PKT_DROP(drop), .PKT_EXPLICIT(expl), .TX_FRAME_ID(fid),
      .TX_DEST(dest), .TX_SRC_EP(sep), .TX_DST_EP(dep), .TX_CLUSTER(clu), .TX_PROFILE(pro),
      .TX_HOPS(hops), .TX_OPTIONS(opts), .TX_BCAST(bcast), .TX_NO_ACK(no_ack),
      .TX_METHOD(meth), .TX_LOOPBACK(loop), .TX_DONE(tx_done), .TX_RESULT(res),
      .TX_RETRIES(rty), .ST_DATA(st_data), .ST_VALID(st_valid), .ST_READY(st_ready)
   );
   aetx_host_model host (.CLK(clk), .RX_READY(rx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid));
   // Clock of 5 ns period.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Collects taken payload and status bytes and counts verdict pulses.
   always @(posedge clk)
   begin
      if (pl_valid && pl_ready) pq.push_back(pl_data);
      if (st_valid && st_ready) sq.push_back(st_data);
      if (good) ngood++;
      if (drop) ndrop++;
   end
   // Both consumers stall at random.
   always @(negedge clk)
   begin
      pl_ready <= $urandom_range(3) != 0;
      st_ready <= $urandom_range(3) != 0;
   end
   task automatic wrap_up();
      if (errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Builds one frame, sends it and checks verdict, fields, payload and status.
   task automatic frame(logic [7:0] t, f, logic [63:0] d, logic [7:0] s_ep, d_ep,
                        logic [15:0] cl, logic [7:0] rad, opt, int npl, bit bad);
      logic [7:0] b[$];
      logic [7:0] sum, eo, es, ed;
      logic       ok;
      b = {t, f};
      for (int i = 7; i >= 0; i--)
         b.push_back(d[8*i +: 8]);
      b = {b, 8'hFF, 8'hFE};
      if (t == 8'h11)
         b = {b, s_ep, d_ep, cl[15:8], cl[7:0], PROF[15:8], PROF[7:0]};
      b = {b, rad, opt};
      ok = !bad && (t == 8'h10 || t == 8'h11) && npl <= maxp;
      epl.delete();
      repeat (npl)
         epl.push_back(8'($urandom));
      b = {b, epl};
      sum = 8'h00;
      foreach (b[i])
         sum += b[i];
      host.fq = {8'h7E, 8'(b.size() >> 8), 8'(b.size()), b, 8'hFF - sum + 8'(bad)};
      pq.delete();
      sq.delete();
      esq.delete();
      ngood = 0;
      ndrop = 0;
      host.send();
      for (int i = 0; i < 8 && ngood + ndrop == 0; i++)
         @(posedge clk);
      @(negedge clk);
      chk("good", ok, ngood);
      chk("drop", !ok, ndrop);
      if (ok)
      begin
         eo = (opt == 8'h00) ? d_opt : opt;
         es = (t == 8'h10 || (p2p && (s_ep < 8'hDC || s_ep > 8'hEE))) ? 8'hE8 : s_ep;
         ed = (t == 8'h10 || (p2p && (d_ep < 8'hDC || d_ep > 8'hEE))) ? 8'hE8 : d_ep;
         chk("frame id", f, fid);
         chk("dest", d, dest);
         chk("src ep", es, sep);
         chk("dst ep", ed, dep);
         chk("cluster", (t == 8'h11) ? cl : 16'h0011, clu);
         chk("profile", PROF, pro);
         chk("hops", (rad == 8'h00) ? d_hop : rad, hops);
         chk("options", eo, opts);
         chk("bcast", d == 64'hFFFF, bcast);
         chk("no ack", eo[0] && d != 64'hFFFF, no_ack);
         chk("method", eo[7:6], meth);
         chk("loop", t == 8'h11 && ed == 8'hE8 && cl == 16'h0012 && !p2p, loop);
         chk("explicit", t == 8'h11, expl);
         chk("pl count", npl, pq.size());
         foreach (epl[i])
            chk("pl byte", epl[i], pq[i]);
         res = 8'($urandom);
         rty = 8'($urandom);
         tx_done = 1'b1;
         @(negedge clk);
         tx_done = 1'b0;
         if (f != 8'h00 && t == 8'h11)
            esq = {8'h7E, 8'h00, 8'h07, 8'h8B, f, 8'hFF, 8'hFE, rty, res, 8'h00};
         if (f != 8'h00 && t == 8'h10)
            esq = {8'h7E, 8'h00, 8'h03, 8'h89, f, res};
         sum = 8'h00;
         for (int i = 3; i < esq.size(); i++)
            sum += esq[i];
         if (esq.size() > 0)
            esq.push_back(8'hFF - sum);
      end
      for (int i = 0; i < 300 && sq.size() < esq.size(); i++)
         @(negedge clk);
      repeat (20)
         @(negedge clk);
      chk("st count", esq.size(), sq.size());
      foreach (esq[i])
         chk("st byte", esq[i], sq[i]);
   endtask
   // Watchdog against a hung handshake.
   initial
   begin
      #300000;
      errors++;
      wrap_up();
   end
   // Main sequence.
   initial
   begin
      void'($urandom(78));
      reset = 1'b1;
      {tx_done, p2p, res, rty} = '0;
      maxp = 16'h0040;
      d_opt = 8'($urandom_range(255, 1));
      d_hop = 8'($urandom_range(255, 1));
      repeat (6)
         @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      frame(8'h10, 8'h52, ADR, 0, 0, 0, 8'h00, 8'h00, 6, 0);
      frame(8'h10, 8'h00, 64'hFFFF, 0, 0, 0, 8'h01, 8'h00, 9, 0);
      frame(8'h11, 8'h87, ADR, 8'hE8, 8'hE8, 16'h0011, 8'h00, 8'h00, 0, 0);
      frame(8'h11, 8'hF8, ADR, 8'hE8, 8'hE8, 16'h0012, 8'h00, 8'h01, 6, 0);
      frame(8'h11, 8'h33, ADR, 8'hE8, 8'hE8, 16'h0011, 8'h00, 8'h00, 3, 1);
      frame(8'h12, 8'h34, ADR, 0, 0, 0, 8'h00, 8'h00, 2, 0);
      frame(8'h11, 8'h35, '1, 8'hE6, 8'h30, 16'h0012, 8'h05, 8'hC0, 1, 0);
      for (int m = 0; m < 4; m++)
         frame(8'h11, 8'(m + 1), 64'hFFFF, 8'hE8, 8'hE8, 16'h0011, 8'h00, 8'(m << 6) | 8'h01, 2, 0);
      maxp = 16'h0004;
      frame(8'h10, 8'h61, ADR, 0, 0, 0, 8'h00, 8'h00, 4, 0);
      frame(8'h10, 8'h62, ADR, 0, 0, 0, 8'h00, 8'h00, 5, 0);
      maxp = 16'h0040;
      p2p = 1'b1;
      frame(8'h11, 8'h41, ADR, 8'h30, 8'hE6, 16'h0012, 8'h00, 8'h00, 2, 0);
      frame(8'h11, 8'h42, ADR, 8'hDD, 8'hF0, 16'h0012, 8'h00, 8'h00, 2, 0);
      p2p = 1'b0;
      repeat (8)
         frame(8'h10 + 8'($urandom_range(1)), 8'($urandom), ADR ^ 64'($urandom), 8'($urandom),
               8'($urandom), 16'($urandom), 8'($urandom), 8'($urandom), $urandom_range(8),
               $urandom_range(7) == 0);
      wrap_up();
   end
endmodule
`default_nettype wire
